// ### pdet_edge_if.sv
// Carrier for qualified rising-edge pulses between the detector modules.
`timescale 1ns/1ps
interface pdet_edge_if;
	logic ref_rise;
	logic fb_rise;
	modport src (output ref_rise, output fb_rise);
	modport snk (input ref_rise, input fb_rise);
endinterface : pdet_edge_if

// ### pdet_edge_sync.sv
// Input synchroniser and rising-edge qualifier for both comparator inputs.
`timescale 1ns/1ps
module pdet_edge_sync (
	// Clock and synchronised reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Raw asynchronous inputs
	input wire logic reference_in,
	input wire logic feedback_in,
	// Qualified edge pulses
	pdet_edge_if.src edges
);
	logic [pdet_pkg::NUM_INPUTS-1:0] raw;
	logic [pdet_pkg::NUM_INPUTS-1:0] rise_r;

	assign raw = {feedback_in, reference_in};

	// ---------------------------------------------------------------
	// Three-stage synchroniser per input
	// ---------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < pdet_pkg::NUM_INPUTS; gi++) begin : g_in
			logic [pdet_pkg::SYNC_STAGES-1:0] sync_r;
			logic level_r;
			// The first stage feeds only the second; edges are judged
			// on stages two and three so a single-cycle glitch in the
			// third stage alone never counts.
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					sync_r <= '0;
				end else begin
					sync_r <= {sync_r[pdet_pkg::SYNC_STAGES-2:0], raw[gi]};
				end
			end
			// A level change is accepted once stages two and three agree.
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					level_r <= 1'b0;
					rise_r[gi] <= 1'b0;
				end else begin
					rise_r[gi] <= (sync_r[1] == sync_r[2]) && sync_r[2] &&
						!level_r;
					if (sync_r[1] == sync_r[2]) begin
						level_r <= sync_r[2];
					end
				end
			end
		end
	endgenerate

	assign edges.ref_rise = rise_r[pdet_pkg::IDX_REF];
	assign edges.fb_rise = rise_r[pdet_pkg::IDX_FB];

	// Each qualified reference edge is a single-cycle pulse, whatever the duty cycle.
	property p_single_pulse;
		@(posedge sys_clk) disable iff (!rst_n)
		rise_r[pdet_pkg::IDX_REF] |=> !rise_r[pdet_pkg::IDX_REF];
	endproperty
	a_single_pulse: assert property (p_single_pulse)
		else $error("Reference edge pulse lasted more than one cycle.");
endmodule : pdet_edge_sync

// ### pdet_osc_model.sv
// Behavioural oscillator standing at the far side of the pump pin.
`timescale 1ns/1ps
module pdet_osc_model (
	// Clock
	input wire logic sys_clk,
	// Bench control
	input wire logic run,
	input wire logic fb_man,
	input wire logic [31:0] half_cyc,
	// Oscillator output
	output logic feedback_in
);
	int cnt;
	logic run_s;
	logic man_s;
	initial begin
		feedback_in = 1'b0;
		cnt = 0;
		run_s = 1'b0;
		man_s = 1'b0;
	end
	// The frequency stays fixed so phase offsets set by the bench stay exact.
	// Controls are taken at the edge, before the bench moves them, so an
	// offset requested by the bench lands on an exact cycle.
	always @(posedge sys_clk) begin
		run_s = run;
		man_s = fb_man;
		#1;
		if (run_s) begin
			feedback_in = (cnt < half_cyc);
			cnt = (cnt + 1) % (2 * half_cyc);
		end else begin
			feedback_in = man_s;
			cnt = 0;
		end
	end
endmodule : pdet_osc_model

// ### pdet_pkg.sv
// Shared constants for the edge phase detector block.
package pdet_pkg;
	// -------------------------------------------------------------
	// Clocking and input conditioning
	// -------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int SYNC_STAGES = 3;
	localparam int NUM_INPUTS = 2;
	localparam int IDX_REF = 0;
	localparam int IDX_FB = 1;
	localparam int RST_STAGES = 2;
	// -------------------------------------------------------------
	// Missing-reference detection for the set/reset detector
	// -------------------------------------------------------------
	localparam int NO_REF_TIME_NS = 262144;
	localparam int NO_REF_CYCLES = NO_REF_TIME_NS / CLK_PERIOD_NS;
	localparam int NO_REF_CNT_W = 24;
	// Pump direction states of the tri-state comparator.
	typedef enum logic [1:0] {
		PDET_IDLE,
		PDET_UP,
		PDET_DOWN
	} pdet_pump_t;
endpackage : pdet_pkg

// ### pdet_top.sv
// Edge phase detectors: tri-state pump comparator and set/reset detector.
`timescale 1ns/1ps
module pdet_top #(
	parameter int NO_REF_CYCLES = pdet_pkg::NO_REF_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Comparator inputs
	input wire logic reference_in,
	input wire logic feedback_in,
	// Tri-state pump pin and lock indication
	output logic tristate_pump_out,
	output logic tristate_pump_oe,
	output logic lock_pulse_out,
	// Set/reset detector output
	output logic rs_detector_out
);
	// -------------------------------------------------------------
	// Reset release
	// -------------------------------------------------------------
	logic [pdet_pkg::RST_STAGES-1:0] rst_sync_r;
	logic rst_n;

	// Release is synchronised so no flop leaves reset on a split edge.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_r <= '0;
		end else begin
			rst_sync_r <= {rst_sync_r[pdet_pkg::RST_STAGES-2:0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[pdet_pkg::RST_STAGES-1];

	// -------------------------------------------------------------
	// Edge qualification
	// -------------------------------------------------------------
	pdet_edge_if edges ();

	pdet_edge_sync u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.reference_in(reference_in),
		.feedback_in(feedback_in),
		.edges(edges.src)
	);

	logic ref_rise;
	logic fb_rise;
	assign ref_rise = edges.ref_rise;
	assign fb_rise = edges.fb_rise;

	// -------------------------------------------------------------
	// Tri-state comparator
	// -------------------------------------------------------------
	pdet_pkg::pdet_pump_t pump_r;
	pdet_pkg::pdet_pump_t pump_nxt;

	// Two edge memories collapse into one state: seeing the other
	// input's edge clears both, and coincident edges leave it floating.
	always_comb begin
		pump_nxt = pump_r;
		unique case (pump_r)
			pdet_pkg::PDET_IDLE: begin
				if (ref_rise && !fb_rise) begin
					pump_nxt = pdet_pkg::PDET_UP;
				end else if (fb_rise && !ref_rise) begin
					pump_nxt = pdet_pkg::PDET_DOWN;
				end
			end
			pdet_pkg::PDET_UP: begin
				if (fb_rise) begin
					pump_nxt = pdet_pkg::PDET_IDLE;
				end
			end
			pdet_pkg::PDET_DOWN: begin
				if (ref_rise) begin
					pump_nxt = pdet_pkg::PDET_IDLE;
				end
			end
			default: begin
				pump_nxt = pdet_pkg::PDET_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pump_r <= pdet_pkg::PDET_IDLE;
		end else begin
			pump_r <= pump_nxt;
		end
	end

	// Pin drivers are registered from the next state so they line up
	// with the state flop and come straight from flip-flops.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tristate_pump_out <= 1'b0;
			tristate_pump_oe <= 1'b0;
			lock_pulse_out <= 1'b1;
		end else begin
			tristate_pump_out <= (pump_nxt == pdet_pkg::PDET_UP);
			tristate_pump_oe <= (pump_nxt != pdet_pkg::PDET_IDLE);
			lock_pulse_out <= (pump_nxt == pdet_pkg::PDET_IDLE);
		end
	end

	// -------------------------------------------------------------
	// Set/reset detector
	// -------------------------------------------------------------
	// Last count before the reference is treated as missing.
	localparam logic [pdet_pkg::NO_REF_CNT_W-1:0] NO_REF_CNT_MAX =
		pdet_pkg::NO_REF_CNT_W'(NO_REF_CYCLES - 1);

	logic [pdet_pkg::NO_REF_CNT_W-1:0] no_ref_cnt_r;
	logic no_ref_r;

	// Watch for a missing reference so the loop is pushed to fmax
	// rather than parked at fmin by the feedback resets alone.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			no_ref_cnt_r <= '0;
			no_ref_r <= 1'b0;
		end else if (ref_rise) begin
			no_ref_cnt_r <= '0;
			no_ref_r <= 1'b0;
		end else if (no_ref_cnt_r ==
			NO_REF_CNT_MAX) begin
			no_ref_r <= 1'b1;
		end else begin
			no_ref_cnt_r <= no_ref_cnt_r + 1'b1;
		end
	end

	// Reference sets, feedback resets; the span covers a full cycle,
	// so half duty falls at 180 degrees. Coincident edges hold.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rs_detector_out <= 1'b0;
		end else if (no_ref_r) begin
			rs_detector_out <= 1'b1;
		end else if (ref_rise && !fb_rise) begin
			rs_detector_out <= 1'b1;
		end else if (fb_rise && !ref_rise) begin
			rs_detector_out <= 1'b0;
		end
	end

	// -------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------
	property p_ref_lead_up;
		@(posedge sys_clk) disable iff (!rst_n)
		(ref_rise && !fb_rise && pump_r == pdet_pkg::PDET_IDLE) |=>
			(tristate_pump_oe && tristate_pump_out);
	endproperty
	a_ref_lead_up: assert property (p_ref_lead_up)
		else $error("Pump not driven high after leading reference edge.");

	property p_up_holds;
		@(posedge sys_clk) disable iff (!rst_n)
		(tristate_pump_out && !fb_rise) |=> tristate_pump_out;
	endproperty
	a_up_holds: assert property (p_up_holds)
		else $error("Pump high ended before a feedback edge.");

	property p_up_release;
		@(posedge sys_clk) disable iff (!rst_n)
		(pump_r == pdet_pkg::PDET_UP && fb_rise) |=>
			(!tristate_pump_oe && lock_pulse_out);
	endproperty
	a_up_release: assert property (p_up_release)
		else $error("Pump not floated after feedback edge.");

	property p_fb_lead_down;
		@(posedge sys_clk) disable iff (!rst_n)
		(fb_rise && !ref_rise && pump_r == pdet_pkg::PDET_IDLE) |=>
			(tristate_pump_oe && !tristate_pump_out);
	endproperty
	a_fb_lead_down: assert property (p_fb_lead_down)
		else $error("Pump not driven low after leading feedback edge.");

	property p_lock_flag;
		@(posedge sys_clk) disable iff (!rst_n)
		lock_pulse_out == !tristate_pump_oe;
	endproperty
	a_lock_flag: assert property (p_lock_flag)
		else $error("Lock pulse disagrees with pump float state.");

	property p_down_only_fb;
		@(posedge sys_clk) disable iff (!rst_n)
		(tristate_pump_oe && !tristate_pump_out && !ref_rise) |=>
			(tristate_pump_oe && !tristate_pump_out);
	endproperty
	a_down_only_fb: assert property (p_down_only_fb)
		else $error("Pump low released without a reference edge.");

	property p_coincide_float;
		@(posedge sys_clk) disable iff (!rst_n)
		(ref_rise && fb_rise && pump_r == pdet_pkg::PDET_IDLE) |=>
			!tristate_pump_oe;
	endproperty
	a_coincide_float: assert property (p_coincide_float)
		else $error("Coincident edges drove the pump.");

	property p_rs_set;
		@(posedge sys_clk) disable iff (!rst_n)
		(ref_rise && !fb_rise) |=> rs_detector_out;
	endproperty
	a_rs_set: assert property (p_rs_set)
		else $error("Set/reset detector not set by reference edge.");

	property p_rs_reset;
		@(posedge sys_clk) disable iff (!rst_n)
		(fb_rise && !ref_rise && !no_ref_r) |=> !rs_detector_out;
	endproperty
	a_rs_reset: assert property (p_rs_reset)
		else $error("Set/reset detector not reset by feedback edge.");

	property p_rs_no_ref;
		@(posedge sys_clk) disable iff (!rst_n)
		(no_ref_r && !ref_rise) |=> (no_ref_r && rs_detector_out);
	endproperty
	a_rs_no_ref: assert property (p_rs_no_ref)
		else $error("Missing reference did not hold detector high.");
endmodule : pdet_top

// ### tb.sv
// Self-checking testbench for the edge phase detectors.
`timescale 1ns/1ps
module tb;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic reference_in = 1'b0;
	logic fb_man = 1'b0;
	logic osc_run = 1'b0;
	logic ref_run = 1'b0;
	int ref_cnt = 0;
	logic feedback_in;
	logic tristate_pump_out;
	logic tristate_pump_oe;
	logic lock_pulse_out;
	logic rs_detector_out;
	int errors = 0;
	int check_count = 0;
	always #2 sys_clk = ~sys_clk;
	// The missing-reference span is cut short to 48 cycles for simulation, so it
	// runs out in the oscillator-only scenario and in the long wait of t_fb_leads.
	pdet_top #(.NO_REF_CYCLES(48)) i_pdet_top (
		.sys_clk(sys_clk), .arst_n(arst_n), .reference_in(reference_in),
		.feedback_in(feedback_in), .tristate_pump_out(tristate_pump_out),
		.tristate_pump_oe(tristate_pump_oe), .lock_pulse_out(lock_pulse_out),
		.rs_detector_out(rs_detector_out));
	pdet_osc_model i_pdet_osc_model (
		.sys_clk(sys_clk), .run(osc_run), .fb_man(fb_man),
		.half_cyc(32'h0000000a), .feedback_in(feedback_in));
	// -------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------
	// Periodic reference with the same 20-cycle period as the oscillator.
	// The run flag is taken at the edge so the phase offset is exact.
	logic ref_go = 1'b0;
	always @(posedge sys_clk) begin
		ref_go = ref_run;
		#1;
		if (ref_go) begin
			reference_in = (ref_cnt < 10);
			ref_cnt = (ref_cnt + 1) % 20;
		end else begin
			ref_cnt = 0;
		end
	end
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step
	task automatic check(input string name, input logic [31:0] seen,
			input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict
	// -------------------------------------------------------------
	// Scenarios
	// -------------------------------------------------------------
	// A short reference pulse still holds the pump up for a long wait.
	task automatic t_ref_leads;
		reference_in = 1'b1;
		step(3);
		reference_in = 1'b0;
		step(30);
		check("oe", tristate_pump_oe, 1);
		check("pump", tristate_pump_out, 1);
		check("lock", lock_pulse_out, 0);
		check("rs", rs_detector_out, 1);
		fb_man = 1'b1;
		step(8);
		check("oe", tristate_pump_oe, 0);
		check("lock", lock_pulse_out, 1);
		check("rs", rs_detector_out, 0);
		fb_man = 1'b0;
		step(4);
		$display("test ref_leads done");
	endtask : t_ref_leads
	task automatic t_fb_leads;
		fb_man = 1'b1;
		step(8);
		check("oe", tristate_pump_oe, 1);
		check("pump", tristate_pump_out, 0);
		check("lock", lock_pulse_out, 0);
		fb_man = 1'b0;
		step(10);
		reference_in = 1'b1;
		step(6);
		check("oe", tristate_pump_oe, 0);
		check("lock", lock_pulse_out, 1);
		reference_in = 1'b0;
		step(4);
		$display("test fb_leads done");
	endtask : t_fb_leads
	// Reference leads the oscillator by d cycles; counts over two periods.
	task automatic t_periodic(input int d);
		int up_n;
		int rs_n;
		int lk_n;
		up_n = 0;
		rs_n = 0;
		lk_n = 0;
		ref_run = 1'b1;
		step(d);
		osc_run = 1'b1;
		step(100);
		repeat (40) begin
			if (tristate_pump_oe === 1'b1 && tristate_pump_out === 1'b1) up_n++;
			if (rs_detector_out === 1'b1) rs_n++;
			if (lock_pulse_out === 1'b1) lk_n++;
			step(1);
		end
		check("up_cycles", up_n, 2 * d);
		check("lock_cycles", lk_n, 40 - 2 * d);
		if (d > 0) check("rs_cycles", rs_n, 2 * d);
		ref_run = 1'b0;
		osc_run = 1'b0;
		// One edge passes so the generators see the stop before the pin moves.
		step(1);
		reference_in = 1'b0;
		step(10);
		$display("test periodic %0d done", d);
	endtask : t_periodic
	// Oscillator alone: pump held low, set/reset output held high.
	task automatic t_no_ref;
		int dn_n;
		int rs_n;
		dn_n = 0;
		rs_n = 0;
		osc_run = 1'b1;
		step(60);
		repeat (40) begin
			if (tristate_pump_oe === 1'b1 && tristate_pump_out === 1'b0) dn_n++;
			if (rs_detector_out === 1'b1) rs_n++;
			step(1);
		end
		check("down_cycles", dn_n, 40);
		check("rs_cycles", rs_n, 40);
		osc_run = 1'b0;
		$display("test no_ref done");
	endtask : t_no_ref
	// -------------------------------------------------------------
	// Main sequence and watchdog
	// -------------------------------------------------------------
	initial begin
		step(10);
		arst_n = 1'b1;
		step(5);
		check("oe", tristate_pump_oe, 0);
		check("lock", lock_pulse_out, 1);
		check("rs", rs_detector_out, 0);
		t_ref_leads();
		t_fb_leads();
		t_periodic(5);
		t_periodic(10);
		t_periodic(0);
		t_no_ref();
		give_verdict();
	end
	initial begin
		#20000;
		errors++;
		give_verdict();
	end
endmodule : tb
